// ==== hpm_consts.vh ====
// hpm_consts.vh
// holds constants for the host port pin mux: pin indices, reset values, gpio modes.
// assumes it is included by bare name into each design file of the block.
`ifndef HPM_CONSTS_VH
`define HPM_CONSTS_VH

// ----------------------------------------------------------------------------
// shared pad indices
// ----------------------------------------------------------------------------
`define HPM_NPINS          4
`define HPM_PIN_CS         0
`define HPM_PIN_REQ        1
`define HPM_PIN_ACK        2
`define HPM_PIN_SEL        3

// ----------------------------------------------------------------------------
// gpio direction encodings, two bits per pin
// ----------------------------------------------------------------------------
`define HPM_GPIO_DISC      2'h0
`define HPM_GPIO_IN        2'h1
`define HPM_GPIO_OUT       2'h2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define HPM_RST_POL        1'h0
`define HPM_RST_FUNC       4'h0
`define HPM_RST_BIT        1'h0

`endif

// ==== hpm_sync.v ====
// hpm_sync.v
// holds a two flip-flop synchroniser for a vector of pad inputs.
// assumes inputs come from pins outside the clk_in domain.
`timescale 1ns/10ps
`default_nettype none
`include "hpm_consts.vh"

module hpm_sync #(
   parameter W = 4
) (
   input  wire         clk_in,
   input  wire         resetn_in,
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] stable_ff;

   // ----------------------------------------------------------------------------
   // two stage capture; first stage feeds the second only
   // ----------------------------------------------------------------------------
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_ff   <= {W{1'b0}};
         stable_ff <= {W{1'b0}};
      end else begin
         meta_ff   <= async_in;
         stable_ff <= meta_ff;
      end
   end

   assign sync_out = stable_ff;

endmodule
`default_nettype wire

// ==== hpm_gpio_bit.v ====
// hpm_gpio_bit.v
// holds one shared gpio pin slice: direction select and output data.
// assumes each core writes its own fields; last writer wins, core 1 on a tie.
`timescale 1ns/10ps
`default_nettype none
`include "hpm_consts.vh"

module hpm_gpio_bit (
   input  wire       clk_in,
   input  wire       resetn_in,
   input  wire       core0_wr_in,
   input  wire [1:0] core0_dir_in,
   input  wire       core0_data_in,
   input  wire       core1_wr_in,
   input  wire [1:0] core1_dir_in,
   input  wire       core1_data_in,
   output reg  [1:0] dir_out,
   output reg        data_out
);

   // ----------------------------------------------------------------------------
   // per pin direction and data; either core may update just this pin
   // ----------------------------------------------------------------------------
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dir_out  <= `HPM_GPIO_DISC;              // disconnected after reset
         data_out <= `HPM_RST_BIT;
      end else if (core1_wr_in) begin
         dir_out  <= core1_dir_in;
         data_out <= core1_data_in;
      end else if (core0_wr_in) begin
         dir_out  <= core0_dir_in;
         data_out <= core0_data_in;
      end
   end

endmodule
`default_nettype wire

// ==== hpm_top.v ====
// hpm_top.v
// holds the host port pin mux: function select, pin roles, polarity, drive type,
// and steering to the primary or secondary host port module.
// assumes config bits are static-ish controls on clk_in; pads arrive asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "hpm_consts.vh"

module hpm_top (
   input  wire       clk_in,
   input  wire       resetn_in,
   // configuration
   input  wire [3:0] host_port_function_in,
   input  wire       muxed_bus_in,
   input  wire       double_request_in,
   input  wire       double_strobe_in,
   input  wire       cs_pol_high_in,
   input  wire       req_pol_high_in,
   input  wire       ack_pol_high_in,
   input  wire       strobe_pol_high_in,
   input  wire       req_open_drain_in,
   // gpio control from both cores
   input  wire [3:0] core0_wr_in,
   input  wire [7:0] core0_dir_in,
   input  wire [3:0] core0_data_in,
   input  wire [3:0] core1_wr_in,
   input  wire [7:0] core1_dir_in,
   input  wire [3:0] core1_data_in,
   output reg  [3:0] gpio_read_out,
   // pads: 0 cs/addr10, 1 request, 2 ack/receive request, 3 module select
   input  wire [3:0] pad_in,
   output reg  [3:0] pad_out,
   output reg  [3:0] pad_oe_out,
   input  wire       read_strobe_in,
   input  wire       write_strobe_in,
   // host port modules: requests in, decoded controls out
   input  wire       prim_req_in,
   input  wire       prim_rx_req_in,
   input  wire       sec_req_in,
   input  wire       sec_rx_req_in,
   output reg        prim_host_chip_select_out,
   output reg        prim_host_address_line_ten_out,
   output reg        prim_host_ack_out,
   output reg        prim_read_strobe_out,
   output reg        prim_write_strobe_out,
   output reg        sec_host_chip_select_out,
   output reg        sec_host_address_line_ten_out,
   output reg        sec_host_ack_out,
   output reg        sec_read_strobe_out,
   output reg        sec_write_strobe_out
);

   // ----------------------------------------------------------------------------
   // pad synchronisation
   // ----------------------------------------------------------------------------
   wire [5:0] sync_w;
   wire [3:0] pad_s;
   wire       rd_s;
   wire       wr_s;

   hpm_sync #(
      .W (6)
   ) u_sync (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .async_in  ({write_strobe_in, read_strobe_in, pad_in}),
      .sync_out  (sync_w)
   );

   assign pad_s = sync_w[3:0];
   assign rd_s  = sync_w[4];
   assign wr_s  = sync_w[5];

   // ----------------------------------------------------------------------------
   // per pin gpio state, one slice per shared pin
   // ----------------------------------------------------------------------------
   wire [7:0] gdir_w;
   wire [3:0] gdat_w;

   genvar gi;
   generate
      for (gi = 0; gi < `HPM_NPINS; gi = gi + 1) begin : g_pin
         hpm_gpio_bit u_bit (
            .clk_in        (clk_in),
            .resetn_in     (resetn_in),
            .core0_wr_in   (core0_wr_in[gi]),
            .core0_dir_in  (core0_dir_in[2*gi+1:2*gi]),
            .core0_data_in (core0_data_in[gi]),
            .core1_wr_in   (core1_wr_in[gi]),
            .core1_dir_in  (core1_dir_in[2*gi+1:2*gi]),
            .core1_data_in (core1_data_in[gi]),
            .dir_out       (gdir_w[2*gi+1:2*gi]),
            .data_out      (gdat_w[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // function select register; reset clears it so every pin starts as gpio
   // ----------------------------------------------------------------------------
   reg [3:0] func_ff;

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         func_ff <= `HPM_RST_FUNC;
      end else begin
         func_ff <= host_port_function_in;
      end
   end

   // module select pad only counts once its pin is in host function
   wire sel_w = func_ff[`HPM_PIN_SEL] & pad_s[`HPM_PIN_SEL];

   // ----------------------------------------------------------------------------
   // host side decode: polarity fold so internal signals are active high
   // ----------------------------------------------------------------------------
   reg nxt_cs;
   reg nxt_a10;
   reg nxt_ack;
   reg nxt_rd;
   reg nxt_wr;

   always @* begin
      nxt_cs  = 1'b0;
      nxt_a10 = 1'b0;
      nxt_ack = 1'b0;
      nxt_rd  = 1'b0;
      nxt_wr  = 1'b0;
      if (func_ff[`HPM_PIN_CS]) begin
         if (muxed_bus_in)
            nxt_a10 = pad_s[`HPM_PIN_CS];
         else
            nxt_cs = pad_s[`HPM_PIN_CS] ~^ cs_pol_high_in;
      end
      if (func_ff[`HPM_PIN_ACK] && !double_request_in)
         nxt_ack = pad_s[`HPM_PIN_ACK] ~^ ack_pol_high_in;
      if (func_ff[`HPM_PIN_CS] && double_strobe_in) begin
         nxt_rd = rd_s ~^ strobe_pol_high_in;
         nxt_wr = wr_s ~^ strobe_pol_high_in;
      end
   end

   // ----------------------------------------------------------------------------
   // steer decoded inputs to one module; the other sees all inactive
   // ----------------------------------------------------------------------------
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prim_host_chip_select_out      <= 1'b0;
         prim_host_address_line_ten_out <= 1'b0;
         prim_host_ack_out              <= 1'b0;
         prim_read_strobe_out           <= 1'b0;
         prim_write_strobe_out          <= 1'b0;
         sec_host_chip_select_out       <= 1'b0;
         sec_host_address_line_ten_out  <= 1'b0;
         sec_host_ack_out               <= 1'b0;
         sec_read_strobe_out            <= 1'b0;
         sec_write_strobe_out           <= 1'b0;
      end else begin
         prim_host_chip_select_out      <= nxt_cs  & ~sel_w;
         prim_host_address_line_ten_out <= nxt_a10 & ~sel_w;
         prim_host_ack_out              <= nxt_ack & ~sel_w;
         prim_read_strobe_out           <= nxt_rd  & ~sel_w;
         prim_write_strobe_out          <= nxt_wr  & ~sel_w;
         sec_host_chip_select_out       <= nxt_cs  &  sel_w;
         sec_host_address_line_ten_out  <= nxt_a10 &  sel_w;
         sec_host_ack_out               <= nxt_ack &  sel_w;
         sec_read_strobe_out            <= nxt_rd  &  sel_w;
         sec_write_strobe_out           <= nxt_wr  &  sel_w;
      end
   end

   // ----------------------------------------------------------------------------
   // request outputs: pick source module, apply polarity and drive type
   // ----------------------------------------------------------------------------
   wire req_act_w = sel_w ? sec_req_in    : prim_req_in;
   wire rx_act_w  = sel_w ? sec_rx_req_in : prim_rx_req_in;
   wire req_lvl_w = req_act_w ~^ req_pol_high_in;
   wire rx_lvl_w  = rx_act_w  ~^ req_pol_high_in;

   reg [3:0] nxt_pad;
   reg [3:0] nxt_oe;
   integer   pi;

   // host function wins per pin; gpio only drives when not host owned
   always @* begin
      nxt_pad = 4'h0;
      nxt_oe  = 4'h0;
      for (pi = 0; pi < `HPM_NPINS; pi = pi + 1) begin
         if (!func_ff[pi] && gdir_w[2*pi +: 2] == `HPM_GPIO_OUT) begin
            nxt_pad[pi] = gdat_w[pi];
            nxt_oe[pi]  = 1'b1;
         end
      end
      if (func_ff[`HPM_PIN_REQ]) begin
         nxt_pad[`HPM_PIN_REQ] = req_lvl_w;
         // open drain only pulls low, floats for a high level
         nxt_oe[`HPM_PIN_REQ]  = ~req_open_drain_in | ~req_lvl_w;
      end
      if (func_ff[`HPM_PIN_ACK] && double_request_in) begin
         nxt_pad[`HPM_PIN_ACK] = rx_lvl_w;
         nxt_oe[`HPM_PIN_ACK]  = ~req_open_drain_in | ~rx_lvl_w;
      end
   end

   // ----------------------------------------------------------------------------
   // registered pad drivers and gpio readback
   // ----------------------------------------------------------------------------
   reg [3:0] nxt_rd_back;
   integer   pj;

   // disconnected or host owned pins read as zero, so no stray level leaks in
   always @* begin
      nxt_rd_back = 4'h0;
      for (pj = 0; pj < `HPM_NPINS; pj = pj + 1) begin
         if (!func_ff[pj] && gdir_w[2*pj +: 2] == `HPM_GPIO_IN)
            nxt_rd_back[pj] = pad_s[pj];
         else if (!func_ff[pj] && gdir_w[2*pj +: 2] == `HPM_GPIO_OUT)
            nxt_rd_back[pj] = gdat_w[pj];
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pad_out       <= 4'h0;
         pad_oe_out    <= 4'h0;
         gpio_read_out <= 4'h0;
      end else begin
         pad_out       <= nxt_pad;
         pad_oe_out    <= nxt_oe;
         gpio_read_out <= nxt_rd_back;
      end
   end

endmodule
`default_nettype wire

// ==== hpm_assertions.sv ====
// hpm_assertions.sv
// holds the port-level checker for hpm_top and its bind.
// assumes clk_in at 200 MHz and an asynchronous active-low resetn_in.
`timescale 1ns/10ps
`default_nettype none

module hpm_assertions (
   input wire logic       clk_in,
   input wire logic       resetn_in,
   input wire logic [3:0] host_port_function_in,
   input wire logic       muxed_bus_in,
   input wire logic       double_request_in,
   input wire logic       double_strobe_in,
   input wire logic       cs_pol_high_in,
   input wire logic       req_pol_high_in,
   input wire logic       ack_pol_high_in,
   input wire logic       strobe_pol_high_in,
   input wire logic       req_open_drain_in,
   input wire logic [3:0] core0_wr_in,
   input wire logic [7:0] core0_dir_in,
   input wire logic [3:0] core0_data_in,
   input wire logic [3:0] core1_wr_in,
   input wire logic [3:0] gpio_read_out,
   input wire logic [3:0] pad_in,
   input wire logic [3:0] pad_out,
   input wire logic [3:0] pad_oe_out,
   input wire logic       read_strobe_in,
   input wire logic       prim_req_in,
   input wire logic       prim_rx_req_in,
   input wire logic       prim_host_chip_select_out,
   input wire logic       prim_host_address_line_ten_out,
   input wire logic       prim_host_ack_out,
   input wire logic       prim_read_strobe_out,
   input wire logic       sec_host_chip_select_out
);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // config, pad, read strobe, primary request and write-enable inputs bundled so one $stable covers pad sync and config latency
   wire [26:0] all_in = {host_port_function_in, muxed_bus_in, double_request_in,
      double_strobe_in, cs_pol_high_in, req_pol_high_in, ack_pol_high_in,
      strobe_pol_high_in, req_open_drain_in, pad_in, read_strobe_in, prim_req_in,
      prim_rx_req_in, core0_wr_in, core1_wr_in};
   wire [3:0] f = host_port_function_in;
   wire req_lvl = ~(prim_req_in ^ req_pol_high_in);
   wire rx_lvl = ~(prim_rx_req_in ^ req_pol_high_in);
   // open drain may only release the pad while the wanted level is high
   function automatic logic drv_ok(logic oe, logic o, logic lvl, logic od);
      return (oe == (!od || !lvl)) && (!oe || o == lvl);
   endfunction

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   chk_reset_quiet: assert property ($rose(resetn_in) |-> pad_oe_out == 4'h0
      && gpio_read_out == 4'h0 && !prim_host_chip_select_out) else $error("pads not idle");
   chk_cs_decode: assert property ((f[0] && !f[3] && !muxed_bus_in && $stable(all_in))[*5]
      |-> prim_host_chip_select_out == (pad_in[0] == cs_pol_high_in)) else $error("cs decode");
   chk_addr_ten: assert property ((f[0] && !f[3] && muxed_bus_in && $stable(all_in))[*5]
      |-> prim_host_address_line_ten_out == pad_in[0] && !prim_host_chip_select_out)
      else $error("address ten");
   chk_module_route: assert property ((f[0] && f[3] && pad_in[3] && !muxed_bus_in
      && $stable(all_in))[*5] |-> !prim_host_chip_select_out
      && sec_host_chip_select_out == (pad_in[0] == cs_pol_high_in)) else $error("route");
   chk_single_req: assert property ((f[1] && !f[3] && !double_request_in && $stable(all_in))[*3]
      |-> drv_ok(pad_oe_out[1], pad_out[1], req_lvl, req_open_drain_in)) else $error("req pad");
   chk_double_req: assert property ((f[2:1] == 2'h3 && !f[3] && double_request_in
      && $stable(all_in))[*3] |-> drv_ok(pad_oe_out[1], pad_out[1], req_lvl, req_open_drain_in)
      && drv_ok(pad_oe_out[2], pad_out[2], rx_lvl, req_open_drain_in)) else $error("tx rx req");
   chk_ack_decode: assert property ((f[2] && !f[3] && !double_request_in && $stable(all_in))[*5]
      |-> prim_host_ack_out == (pad_in[2] == ack_pol_high_in)) else $error("ack decode");
   chk_read_strobe: assert property ((f[0] && !f[3] && double_strobe_in && $stable(all_in))[*5]
      |-> prim_read_strobe_out == (read_strobe_in == strobe_pol_high_in)) else $error("strobe");
   chk_gpio_drive: assert property (core0_wr_in[1] && !core1_wr_in[1] && !f[1] ##1 !f[1]
      ##1 !f[1] |-> pad_oe_out[1] == ($past(core0_dir_in[3:2], 2) == 2'h2)
      && (!pad_oe_out[1] || pad_out[1] == $past(core0_data_in[1], 2))) else $error("gpio pad");
endmodule

bind hpm_top hpm_assertions i_hpm_assertions (.*);
`default_nettype wire

// ==== hpm_host_model.sv ====
// hpm_host_model.sv
// holds the external host side of the shared pads: wire resolution and pulls.
// assumes the bench supplies the host's own drive level and enable per pad.
`timescale 1ns/10ps
`default_nettype none

module hpm_host_model (
   input  wire logic [3:0] dev_level_in,
   input  wire logic [3:0] dev_oe_in,
   input  wire logic [3:0] host_level_in,
   input  wire logic [3:0] host_oe_in,
   output wire logic [3:0] wire_out
);
   // request and ack pads pull up, cs and select pads pull down
   localparam logic [3:0] PULL_UP = 4'h6;
   // device drive wins; an undriven pad shows its pull, never a stale value
   assign wire_out = (dev_oe_in & dev_level_in) | (~dev_oe_in & host_oe_in & host_level_in)
      | (~dev_oe_in & ~host_oe_in & PULL_UP);
endmodule
`default_nettype wire

// ==== host_port_pin_mux_bench.sv ====
// host_port_pin_mux_bench.sv
// holds the self-checking bench for hpm_top with the host model on its pads.
// assumes hpm_top and hpm_assertions are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

module host_port_pin_mux_bench;
   logic       clk_in, resetn_in, muxed_bus_in, double_request_in, double_strobe_in;
   logic       cs_pol_high_in, req_pol_high_in, ack_pol_high_in, strobe_pol_high_in;
   logic       req_open_drain_in, read_strobe_in, write_strobe_in, prim_req_in, prim_rx_req_in;
   logic       sec_req_in, sec_rx_req_in, prim_host_chip_select_out, prim_host_ack_out;
   logic       prim_host_address_line_ten_out, prim_read_strobe_out, prim_write_strobe_out;
   logic       sec_host_chip_select_out, sec_host_address_line_ten_out, sec_host_ack_out;
   logic       sec_read_strobe_out, sec_write_strobe_out;
   logic [3:0] host_port_function_in, core0_wr_in, core0_data_in, core1_wr_in, core1_data_in;
   logic [3:0] pad_in, pad_out, pad_oe_out, gpio_read_out, host_lvl, host_oe;
   logic [7:0] core0_dir_in, core1_dir_in;
   int         bad_count = 0;
   int         check_count = 0;

   hpm_top i_hpm_top (.*);
   hpm_host_model i_hpm_host_model (.dev_level_in(pad_out), .dev_oe_in(pad_oe_out),
      .host_level_in(host_lvl), .host_oe_in(host_oe), .wire_out(pad_in));

   // ------------------------------------------------------------------
   // clock, helpers
   // ------------------------------------------------------------------
   always #2.5 clk_in = ~clk_in;
   // inputs always move 1 ns after an edge so no race with the design
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // single write pulse to pin 1 from one core
   task automatic wr_pin1(input bit core1, input logic [1:0] dir, input logic d);
      if (core1) {core1_wr_in, core1_dir_in[3:2]} = {4'h2, dir};
      else {core0_wr_in, core0_dir_in[3:2], core0_data_in[1]} = {4'h2, dir, d};
      step(1);
      {core0_wr_in, core1_wr_in} = 8'h00;
      step(8);
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_chip_select;
      {host_port_function_in, host_oe, host_lvl} = 12'h110;
      step(8);
      cmp(prim_host_chip_select_out, 4'h1);
      host_lvl = 4'h1;
      step(8);
      cmp(prim_host_chip_select_out, 4'h0);
      cs_pol_high_in = 1'b1;
      step(8);
      cmp({prim_host_address_line_ten_out, prim_host_chip_select_out}, 4'h1);
      muxed_bus_in = 1'b1;
      step(8);
      cmp({prim_host_address_line_ten_out, prim_host_chip_select_out}, 4'h2);
      {muxed_bus_in, cs_pol_high_in, host_port_function_in, host_oe, host_lvl} = 14'h0998;
      step(8);
      cmp({prim_host_chip_select_out, sec_host_chip_select_out}, 4'h1);
      host_lvl = 4'h0;
      step(8);
      cmp({prim_host_chip_select_out, sec_host_chip_select_out}, 4'h2);
   endtask
   task automatic t_requests;
      {host_port_function_in, host_oe, host_lvl, prim_req_in} = 13'h0C81;
      step(8);
      cmp({prim_host_ack_out, pad_in[1]}, 4'h2);
      {host_lvl, prim_req_in} = 5'h08;
      step(8);
      cmp({prim_host_ack_out, pad_in[1]}, 4'h1);
      {ack_pol_high_in, req_pol_high_in} = 2'h3;
      step(8);
      cmp({prim_host_ack_out, pad_in[1]}, 4'h2);
      {req_pol_high_in, req_open_drain_in} = 2'h1;
      step(8);
      cmp({pad_oe_out[1], pad_in[1]}, 4'h1);
      prim_req_in = 1'b1;
      step(8);
      cmp({pad_oe_out[1], pad_in[1]}, 4'h2);
      {host_oe, double_request_in, req_open_drain_in, prim_rx_req_in} = 7'h04;
      step(8);
      cmp(pad_in[2:1], 4'h2);
      {prim_req_in, prim_rx_req_in} = 2'h1;
      step(8);
      cmp(pad_in[2:1], 4'h1);
      {double_request_in, host_port_function_in} = 5'h01;
      {double_strobe_in, read_strobe_in, write_strobe_in} = 3'h5;
      step(8);
      cmp({prim_read_strobe_out, prim_write_strobe_out}, 4'h2);
      strobe_pol_high_in = 1'b1;
      step(8);
      cmp({prim_read_strobe_out, prim_write_strobe_out}, 4'h1);
   endtask
   task automatic t_gpio;
      {host_port_function_in, double_strobe_in, prim_req_in} = 6'h00;
      wr_pin1(1'b0, 2'h2, 1'b0);
      cmp({pad_oe_out[1], pad_in[1]}, 4'h2);
      {host_oe, host_lvl} = 8'h20;
      wr_pin1(1'b1, 2'h1, 1'b0);
      cmp({pad_oe_out[1], gpio_read_out[1]}, 4'h0);
      host_lvl = 4'h2;
      step(8);
      cmp({pad_oe_out[1], gpio_read_out[1]}, 4'h1);
      wr_pin1(1'b0, 2'h0, 1'b0);
      cmp({pad_oe_out[1], gpio_read_out[1]}, 4'h0);
      host_oe = 4'h0;
      wr_pin1(1'b0, 2'h2, 1'b0);
      host_port_function_in = 4'h2;
      step(8);
      cmp({pad_oe_out[1], pad_in[1]}, 4'h3);
   endtask

   // ------------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      {clk_in, resetn_in, muxed_bus_in, double_request_in, double_strobe_in} = 5'h00;
      {cs_pol_high_in, req_pol_high_in, ack_pol_high_in, strobe_pol_high_in} = 4'h0;
      {req_open_drain_in, read_strobe_in, write_strobe_in, prim_req_in} = 4'h0;
      {prim_rx_req_in, sec_req_in, sec_rx_req_in, host_port_function_in} = 7'h00;
      {core0_wr_in, core0_data_in, core1_wr_in, core1_data_in, host_lvl, host_oe} = 24'h0;
      {core0_dir_in, core1_dir_in} = 16'h0000;
      step(3);
      cmp(pad_oe_out | gpio_read_out, 4'h0);
      resetn_in = 1'b1;
      host_oe = 4'hF;
      step(8);
      cmp({pad_oe_out[0], prim_host_chip_select_out}, 4'h0);
      t_chip_select();
      t_requests();
      t_gpio();
      give_verdict();
   end
   // whole run is under 400 cycles; 2000 cycles means a hang
   initial begin
      #10000;
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
